// ==== inc/spc_pkg.sv ====
`default_nettype none
package spc_pkg;

  // ----------------------------------------------------------------
  // register location
  // ----------------------------------------------------------------
  localparam logic [7:0] SPC_CFG_ADDR = 8'hc1;
  localparam logic [3:0] SPC_CFG_PAGE = 4'hf;
  localparam logic [7:0] SPC_CFG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPC_BIT_ENABLE = 7;
  localparam int SPC_BIT_INHIBIT = 6;
  localparam int SPC_BIT_BUSY = 5;
  localparam int SPC_BIT_EXTHOLD = 4;
  localparam int SPC_BIT_TOE = 3;
  localparam int SPC_BIT_FTE = 2;
  localparam int SPC_SRC_MSB = 1;
  localparam int SPC_SRC_LSB = 0;

  // ----------------------------------------------------------------
  // bus free timeout: more than this many source periods
  // ----------------------------------------------------------------
  localparam logic [3:0] SPC_FREE_PERIODS = 4'h0a;

  // ----------------------------------------------------------------
  // bit rate sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPC_SRC_TMR0 = 2'b00,
    SPC_SRC_TMR5 = 2'b01,
    SPC_SRC_TMR2HI = 2'b10,
    SPC_SRC_TMR2LO = 2'b11
  } spc_src_t;

endpackage
`default_nettype wire

// ==== logic/spc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic async,
  output logic synced
);
  logic meta;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b1;
      synced <= 1'b1;
    end else begin
      meta <= async;
      synced <= meta;
    end
  end
endmodule // spc_sync
`default_nettype wire

// ==== logic/spc_port_cfg.sv ====
// Notes on behaviour
// - enable bit activates port and bus watching
// - slave inhibit suppresses slave event interrupts
// - master interrupts pass regardless of inhibit
// - busy flag set while transfer runs
// - busy clears on stop or free timeout
// - hold extension bit selects extended sda timing
// - scl high holds timeout timer in reload
// - scl low lets timeout timer count
// - split timer: only upper byte reloaded
// - bus free after over ten idle periods
// - two bits pick bit rate overflow source
`timescale 1ns/1ps
`default_nettype none
module spc_port_cfg
  import spc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] sfrAddr,
  input wire logic [3:0] sfrPage,
  input wire logic sfrWr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic sdaIn,
  input wire logic sclIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic sclOut,
  output logic sclOe,
  input wire logic tmr0Ovf,
  input wire logic tmr5Ovf,
  input wire logic tmr2HiOvf,
  input wire logic tmr2LoOvf,
  input wire logic tmr4Split,
  input wire logic slaveEvent,
  input wire logic masterEvent,
  output logic irqReq,
  output logic bitRateTick,
  output logic extHoldSel,
  output logic portActive,
  output logic tmr4ReloadLow,
  output logic tmr4ReloadHigh,
  output logic tmr4CountEn,
  output logic busFree
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sdaSync;
  logic sclSync;
  logic sdaPrev;
  logic sclPrev;

  spc_sync u_sda (
    .mclk(mclk),
    .resetn(resetn),
    .async(sdaIn),
    .synced(sdaSync)
  );

  spc_sync u_scl (
    .mclk(mclk),
    .resetn(resetn),
    .async(sclIn),
    .synced(sclSync)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sdaPrev <= 1'b1;
      sclPrev <= 1'b1;
    end else begin
      sdaPrev <= sdaSync;
      sclPrev <= sclSync;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  logic portEnable;
  logic slaveInhibit;
  logic transferBusy;
  logic holdExtension;
  logic sclLowTimeoutEnable;
  logic busFreeTimeoutEnable;
  spc_src_t bitRateSource;
  logic cfgHit;

  assign cfgHit = (sfrAddr == SPC_CFG_ADDR) && (sfrPage == SPC_CFG_PAGE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portEnable <= SPC_CFG_RESET[SPC_BIT_ENABLE];
      slaveInhibit <= SPC_CFG_RESET[SPC_BIT_INHIBIT];
      holdExtension <= SPC_CFG_RESET[SPC_BIT_EXTHOLD];
      sclLowTimeoutEnable <= SPC_CFG_RESET[SPC_BIT_TOE];
      busFreeTimeoutEnable <= SPC_CFG_RESET[SPC_BIT_FTE];
      bitRateSource <= spc_src_t'(SPC_CFG_RESET[SPC_SRC_MSB:SPC_SRC_LSB]);
    end else if (sfrWr && cfgHit) begin
      portEnable <= sfrWdata[SPC_BIT_ENABLE];
      slaveInhibit <= sfrWdata[SPC_BIT_INHIBIT];
      holdExtension <= sfrWdata[SPC_BIT_EXTHOLD];
      sclLowTimeoutEnable <= sfrWdata[SPC_BIT_TOE];
      busFreeTimeoutEnable <= sfrWdata[SPC_BIT_FTE];
      bitRateSource <= spc_src_t'(sfrWdata[SPC_SRC_MSB:SPC_SRC_LSB]);
    end
  end

  // read data, busy bit is read only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sfrRdata <= SPC_CFG_RESET;
    end else if (cfgHit) begin
      sfrRdata <= {portEnable, slaveInhibit, transferBusy, holdExtension,
                   sclLowTimeoutEnable, busFreeTimeoutEnable, bitRateSource};
    end else begin
      sfrRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // bit rate source
  // ----------------------------------------------------------------
  logic next_tick;

  always_comb begin
    unique case (bitRateSource)
      SPC_SRC_TMR0: next_tick = tmr0Ovf;
      SPC_SRC_TMR5: next_tick = tmr5Ovf;
      SPC_SRC_TMR2HI: next_tick = tmr2HiOvf;
      SPC_SRC_TMR2LO: next_tick = tmr2LoOvf;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bitRateTick <= 1'b0;
    end else begin
      bitRateTick <= next_tick && portEnable;
    end
  end

  // ----------------------------------------------------------------
  // start, stop and bus free detection
  // ----------------------------------------------------------------
  logic startSeen;
  logic stopSeen;
  logic freeExpire;
  logic [3:0] freeCount;

  assign startSeen = portEnable && sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopSeen = portEnable && sclSync && sclPrev && !sdaPrev && sdaSync;
  assign freeExpire = busFreeTimeoutEnable && bitRateTick && sdaSync && sclSync && (freeCount == SPC_FREE_PERIODS);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      freeCount <= 4'h0;
    end else if (!portEnable || !busFreeTimeoutEnable || !sdaSync || !sclSync) begin
      freeCount <= 4'h0;
    end else if (bitRateTick && freeCount <= SPC_FREE_PERIODS) begin
      freeCount <= freeCount + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transferBusy <= 1'b0;
      busFree <= 1'b0;
    end else if (!portEnable) begin
      transferBusy <= 1'b0;
      busFree <= 1'b0;
    end else if (startSeen) begin
      transferBusy <= 1'b1;
      busFree <= 1'b0;
    end else if (stopSeen || freeExpire) begin
      transferBusy <= 1'b0;
      busFree <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // scl low timeout timer control
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tmr4ReloadLow <= 1'b0;
      tmr4ReloadHigh <= 1'b0;
      tmr4CountEn <= 1'b1;
    end else if (portEnable && sclLowTimeoutEnable) begin
      tmr4ReloadHigh <= sclSync;
      tmr4ReloadLow <= sclSync && !tmr4Split;
      tmr4CountEn <= !sclSync;
    end else begin
      tmr4ReloadHigh <= 1'b0;
      tmr4ReloadLow <= 1'b0;
      tmr4CountEn <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt gating and pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= portEnable && ((slaveEvent && !slaveInhibit)
                || masterEvent);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      extHoldSel <= 1'b0;
      portActive <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sclOe <= 1'b0;
    end else begin
      extHoldSel <= holdExtension;
      portActive <= portEnable;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      sclOut <= 1'b0;
      sclOe <= 1'b0;
    end
  end

endmodule // spc_port_cfg
`default_nettype wire

// ==== test/spc_port_cfg_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_port_cfg_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sfrWr,
  input wire logic sclIn,
  input wire logic sdaOe,
  input wire logic sclOe,
  input wire logic tmr4Split,
  input wire logic masterEvent,
  input wire logic irqReq,
  input wire logic bitRateTick,
  input wire logic extHoldSel,
  input wire logic portActive,
  input wire logic tmr4ReloadLow,
  input wire logic tmr4ReloadHigh,
  input wire logic tmr4CountEn,
  input wire logic busFree
);
  // ----
  // port checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_master; masterEvent |=> !portActive || irqReq; endproperty
  a_master: assert property (p_master) else $error("master event lost");
  property p_gate; irqReq || bitRateTick |-> portActive; endproperty
  a_gate: assert property (p_gate) else $error("output while off");
  property p_release; !sdaOe && !sclOe; endproperty
  a_release: assert property (p_release) else $error("line driven");
  property p_reload; tmr4ReloadHigh |-> !tmr4CountEn; endproperty
  a_reload: assert property (p_reload) else $error("count in reload");
  property p_split; tmr4ReloadLow |-> tmr4ReloadHigh && !$past(tmr4Split); endproperty
  a_split: assert property (p_split) else $error("low byte reload");
  property p_count; $fell(tmr4ReloadHigh) |-> tmr4CountEn; endproperty
  a_count: assert property (p_count) else $error("count held");
  property p_cfg; $changed(extHoldSel) || $changed(portActive) |-> $past(sfrWr, 2); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
  property p_free; $rose(busFree) |-> $past(sclIn, 3); endproperty
  a_free: assert property (p_free) else $error("free with scl low");
endmodule // spc_port_cfg_asserts
bind spc_port_cfg spc_port_cfg_asserts spc_port_cfg_asserts_inst (.mclk, .resetn, .sfrWr, .sclIn,
  .sdaOe, .sclOe, .tmr4Split, .masterEvent, .irqReq, .bitRateTick, .extHoldSel, .portActive,
  .tmr4ReloadLow, .tmr4ReloadHigh, .tmr4CountEn, .busFree);
`default_nettype wire

// ==== test/spc_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_bus_model (
  output var logic sda,
  output var logic scl
);
  // ----
  // far side lines, pulled high when idle
  // ----
  initial begin
    sda = 1'b1;
    scl = 1'b1;
  end
  // both lines change together, on a falling system clock edge
  task automatic drive(input logic d, input logic c);
    sda = d;
    scl = c;
  endtask
endmodule // spc_bus_model
`default_nettype wire

// ==== test/spc_port_cfg_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module spc_port_cfg_bench
  import spc_pkg::*;
;
  logic mclk, resetn, sfrWr, sdaM, sclM, tmr4Split;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, rdv;
  logic [3:0] sfrPage;
  logic [5:0] ev;
  logic sdaOut, sdaOe, sclOut, sclOe, irqReq, bitRateTick, extHoldSel, portActive;
  logic tmr4ReloadLow, tmr4ReloadHigh, tmr4CountEn, busFree;
  wire sdaW = sdaM & ~(sdaOe & ~sdaOut);
  wire sclW = sclM & ~(sclOe & ~sclOut);
  int miscompares, checked, cyc;
  spc_bus_model spc_bus_model_inst (.sda(sdaM), .scl(sclM));
  spc_port_cfg spc_port_cfg_inst (.mclk, .resetn, .sfrAddr, .sfrPage, .sfrWr, .sfrWdata, .sfrRdata,
    .sdaIn(sdaW), .sclIn(sclW), .sdaOut, .sdaOe, .sclOut, .sclOe, .tmr0Ovf(ev[0]), .tmr5Ovf(ev[1]),
    .tmr2HiOvf(ev[2]), .tmr2LoOvf(ev[3]), .tmr4Split, .slaveEvent(ev[4]), .masterEvent(ev[5]),
    .irqReq, .bitRateTick, .extHoldSel, .portActive, .tmr4ReloadLow, .tmr4ReloadHigh,
    .tmr4CountEn, .busFree);
  // ----
  // access tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    sfrAddr = SPC_CFG_ADDR;
    sfrPage = SPC_CFG_PAGE;
    sfrWdata = d;
    sfrWr = 1'b1;
    tick(1);
    sfrWr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] pg);
    sfrAddr = SPC_CFG_ADDR;
    sfrPage = pg;
    tick(2);
    rdv = sfrRdata;
  endtask
  task automatic pulse(input logic [5:0] v);
    tick(1);
    ev = v;
    tick(1);
    ev = 6'h00;
  endtask
  task automatic line(input logic d, input logic c);
    spc_bus_model_inst.drive(d, c);
    // each line level lasts half of a 32 ns link period
    tick(4);
  endtask
  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    {resetn, sfrWr, tmr4Split, sfrAddr, sfrPage, sfrWdata, ev} = '0;
    {miscompares, checked, cyc} = '0;
    tick(20);
    resetn = 1'b1;
    rd(SPC_CFG_PAGE);
    chk(SPC_CFG_RESET, rdv);
    wr(8'hff);
    rd(SPC_CFG_PAGE);
    chk(8'hdf, rdv);
    rd(4'h0);
    chk(8'h00, rdv);
    for (int s = 0; s < 4; s++) begin
      wr(8'h80 | 8'(s));
      for (int k = 0; k < 4; k++) begin
        pulse(6'(1 << k));
        chk(8'(k == s), 8'(bitRateTick));
      end
    end
    for (int i = 0; i < 2; i++) begin
      wr(i == 1 ? 8'hc0 : 8'h80);
      pulse(6'h10);
      chk(8'(i == 0), 8'(irqReq));
      pulse(6'h20);
      chk(8'h01, 8'(irqReq));
    end
    $display("test done: events");
    wr(8'h90);
    tick(1);
    chk(8'h01, 8'(extHoldSel));
    wr(8'h88);
    tick(2);
    chk(8'h06, 8'({tmr4ReloadLow, tmr4ReloadHigh, tmr4CountEn}));
    tmr4Split = 1'b1;
    tick(2);
    chk(8'h02, 8'({tmr4ReloadLow, tmr4ReloadHigh, tmr4CountEn}));
    line(1'b1, 1'b0);
    chk(8'h01, 8'({tmr4ReloadLow, tmr4ReloadHigh, tmr4CountEn}));
    // software timeout handler resets the port while scl is stuck low
    wr(8'h08);
    tick(1);
    chk(8'h00, 8'(portActive));
    line(1'b1, 1'b1);
    tmr4Split = 1'b0;
    $display("test done: timer");
    wr(8'h80);
    line(1'b0, 1'b1);
    rd(SPC_CFG_PAGE);
    chk(8'ha0, rdv);
    line(1'b1, 1'b1);
    rd(SPC_CFG_PAGE);
    chk(8'h80, rdv);
    chk(8'h01, 8'(busFree));
    wr(8'h84);
    line(1'b0, 1'b1);
    chk(8'h00, 8'(busFree));
    line(1'b0, 1'b0);
    line(1'b1, 1'b0);
    line(1'b1, 1'b1);
    repeat (10) pulse(6'h01);
    rd(SPC_CFG_PAGE);
    chk(8'ha4, rdv);
    pulse(6'h01);
    rd(SPC_CFG_PAGE);
    chk(8'h84, rdv);
    chk(8'h01, 8'(busFree));
    wr(8'h03);
    line(1'b0, 1'b1);
    rd(SPC_CFG_PAGE);
    chk(8'h03, rdv);
    chk(8'h00, 8'(busFree));
    pulse(6'h3f);
    chk(8'h00, 8'({irqReq, bitRateTick}));
    chk(8'h00, 8'({sdaOut, sdaOe, sclOut, sclOe}));
    line(1'b1, 1'b1);
    $display("test done: busy");
    close_out();
  end
endmodule // spc_port_cfg_bench
`default_nettype wire
